//--- bench/bnt_tester.sv
`timescale 1ns/1ps
module bnt_tester
(
    // clock
    input wire logic clk_i,
    // pins driven into the device
    output logic [3:0] md_o,
    output logic [9:0] rbp_o,
    output logic [9:0] rbn_o,
    output logic [17:0] txb_o,
    output logic [3:0] lc_o,
    output logic [18:0] rap_o,
    output logic [18:0] ran_o,
    output logic [37:0] txa_o,
    output logic [79:0] gfx_o,
    output logic [10:0] sys_o
);
    // ****
    // chain levels, position one at bit 0
    // ****
    logic [3:0] md = 4'h0;
    logic [31:0] t1 = '1;
    logic [56:0] t2 = '1;
    logic [79:0] t3 = '1;
    logic [10:0] t4 = '1;
    assign md_o = md;
    assign rbp_o = 10'h3ff;
    assign rbn_o = ~t1[9:0];
    assign txb_o = t1[27:10];
    assign lc_o = t1[31:28];
    assign rap_o = 19'h7ffff;
    assign ran_o = ~t2[18:0];
    assign txa_o = t2[56:19];
    assign gfx_o = t3;
    assign sys_o = t4;
    task set_mode(input logic [3:0] m);
        @(posedge clk_i);
        md <= m;
    endtask : set_mode
    // one input changes per step, in chain order
    task clr(input int k, input int i);
        @(posedge clk_i);
        case (k)
            0: t1[i] <= 1'b0;
            1: t2[i] <= 1'b0;
            2: t3[i] <= 1'b0;
            default: t4[i] <= 1'b0;
        endcase
    endtask : clr
endmodule : bnt_tester

//--- bench/bnt_top_assertions.sv
`timescale 1ns/1ps
module bnt_chk
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pins
    input wire logic test_pin_i,
    input wire logic port_type_detect_pin_i,
    input wire logic link_halt_request_pin_n_i,
    input wire logic strap_pin_zero_i,
    input wire logic link_compensation_pin_three_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    // results
    input wire logic tree_one_result_pin_o,
    input wire logic [3:0] tree_result_oe_o,
    input wire logic sig_pin_oe_o,
    input wire logic [3:0] link_comp_code_o,
    input wire logic [3:0] gfx_comp_code_o,
    input wire logic gfx_new_signaling_o,
    input wire logic avs_waitrequest_o
);
    // ****
    // edges since reset, so $past never reaches into reset
    // ****
    logic [1:0] up_ff;
    logic [1:0] nxt_up;
    logic sel, tr, hz, up;
    always_comb
    begin
        nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
    end
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            up_ff <= 2'h0;
        else
            up_ff <= nxt_up;
    end
    assign up = (up_ff == 2'h3);
    assign sel = test_pin_i && !port_type_detect_pin_i && !link_halt_request_pin_n_i;
    assign tr = sel && strap_pin_zero_i;
    assign hz = sel && !strap_pin_zero_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence bus_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence one_wait;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    tree_oe_a: assert property (up && $past(tr, 2) |-> tree_result_oe_o == 4'hf)
        else $error("result enables off in tree mode");
    hiz_rel_a: assert property (up && $past(hz, 2) |-> !sig_pin_oe_o && tree_result_oe_o == 4'h0)
        else $error("pins driven in high-z mode");
    norm_off_a: assert property (up && !$past(test_pin_i, 2) |-> tree_result_oe_o == 4'h0 && !tree_one_result_pin_o)
        else $error("tree active in normal mode");
    mid_band_a: assert property (up && $past(tr, 2) |-> link_comp_code_o == 4'h8 && gfx_comp_code_o == 4'h8)
        else $error("compensation not mid-band");
    old_sig_a: assert property (up && $past(tr, 2) |-> !gfx_new_signaling_o)
        else $error("new signaling in tree mode");
    and_gate_a: assert property (up && $past(tr, 2) && !$past(link_compensation_pin_three_i) |-> !tree_one_result_pin_o)
        else $error("tree one last gate not and");
    bus_wait_a: assert property (bus_req |=> one_wait)
        else $error("wait cycle count wrong");
    wait_cause_a: assert property (up && !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
endmodule : bnt_chk
bind bnt_top bnt_chk u_chk
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .test_pin_i(test_pin_i),
    .port_type_detect_pin_i(port_type_detect_pin_i),
    .link_halt_request_pin_n_i(link_halt_request_pin_n_i),
    .strap_pin_zero_i(strap_pin_zero_i),
    .link_compensation_pin_three_i(link_compensation_pin_three_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .tree_one_result_pin_o(tree_one_result_pin_o),
    .tree_result_oe_o(tree_result_oe_o),
    .sig_pin_oe_o(sig_pin_oe_o),
    .link_comp_code_o(link_comp_code_o),
    .gfx_comp_code_o(gfx_comp_code_o),
    .gfx_new_signaling_o(gfx_new_signaling_o),
    .avs_waitrequest_o(avs_waitrequest_o)
);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "bnt_params.svh"
module tb_top;
    logic clk_i = 1'b0, nrst_i = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] adr = 4'h0, be = 4'h0;
    logic [31:0] wd = 32'h0, q;
    logic [3:0] md, lc, roe, lcc, gcc, res;
    logic [9:0] rbp, rbn;
    logic [17:0] txb;
    logic [18:0] rap, ran;
    logic [37:0] txa;
    logic [79:0] gfx;
    logic [10:0] sys;
    logic [31:0] rdata;
    logic spoe, nsig, wreq, pv;
    int n_fail = 0, total_checks = 0;
    int lens[4] = '{`BNT_T1_LEN, `BNT_T2_LEN, `BNT_T3_LEN, `BNT_T4_LEN};
    bnt_pkg::bnt_mode_t em;
    initial forever #5 clk_i = ~clk_i;
    bnt_tester tst (.clk_i(clk_i), .md_o(md), .rbp_o(rbp), .rbn_o(rbn), .txb_o(txb),
        .lc_o(lc), .rap_o(rap), .ran_o(ran), .txa_o(txa), .gfx_o(gfx), .sys_o(sys));
    bnt_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .test_pin_i(md[3]),
        .port_type_detect_pin_i(md[2]), .link_halt_request_pin_n_i(md[1]),
        .strap_pin_zero_i(md[0]), .rx_b_p_i(rbp), .rx_b_n_i(rbn), .tx_b_legs_i(txb),
        .link_comp_pins_i(lc[2:0]), .link_compensation_pin_three_i(lc[3]),
        .rx_a_p_i(rap), .rx_a_n_i(ran), .tx_a_legs_i(txa), .gfx_pins_i(gfx),
        .sys_pins_i(sys), .tree_one_result_pin_o(res[0]), .tree_two_result_pin_o(res[1]),
        .tree_three_result_pin_o(res[2]), .tree_four_result_pin_o(res[3]),
        .tree_result_oe_o(roe), .sig_pin_oe_o(spoe), .link_comp_code_o(lcc),
        .gfx_comp_code_o(gcc), .gfx_new_signaling_o(nsig), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));
    // ****
    // helpers
    // ****
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        n_fail += int'(g !== e);
        if (g !== e)
            $display("BAD %s exp %h got %h", nm, e, g);
    endtask : chk
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("bus wait edges", 2, n);
    endtask : acc
    function automatic logic chain(input logic [79:0] v, input int len, input logic la);
        logic r;
        r = 1'b1;
        for (int i = 0; i < len; i++)
            r = (la && i == len - 1) ? (r & v[i]) : ~(r & v[i]);
        return r;
    endfunction : chain
    function automatic logic [3:0] exp_res();
        return {chain(tst.t4, 11, 1'b0), chain(tst.t3, 80, 1'b0),
            chain(tst.t2, 57, 1'b0), chain(tst.t1, 32, 1'b1)};
    endfunction : exp_res
    task final_report();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        final_report();
    end
    // ****
    // tests
    // ****
    initial
    begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        acc(0, `BNT_REG_COMP, 0, 4'hf);
        chk("comp reset", `BNT_COMP_RST, q);
        acc(0, `BNT_REG_CTRL, 0, 4'hf);
        chk("ctrl reset", `BNT_CTRL_RST, q);
        acc(1, 4'hc, 32'hff, 4'hf);
        acc(0, 4'hc, 0, 4'hf);
        chk("unmapped", 0, q);
        acc(1, `BNT_REG_COMP, 32'h5a, 4'hf);
        acc(1, `BNT_REG_COMP, 32'h11, 4'h0);
        acc(0, `BNT_REG_COMP, 0, 4'hf);
        chk("comp rw", 32'h5a, q);
        acc(1, `BNT_REG_CTRL, 0, 4'hf);
        repeat (3) @(posedge clk_i);
        chk("drive off", 0, {spoe, nsig});
        acc(1, `BNT_REG_CTRL, 3, 4'hf);
        for (int m = 0; m < 16; m++)
        begin
            em = (m[3] && !m[2] && !m[1]) ? (m[0] ? bnt_pkg::BNT_TREE : bnt_pkg::BNT_HIZ)
                : bnt_pkg::BNT_NORMAL;
            tst.set_mode(m[3:0]);
            repeat (3) @(posedge clk_i);
            acc(0, `BNT_REG_STATUS, 0, 4'hf);
            chk("mode", em, q[1:0]);
            chk("pin oe", em == bnt_pkg::BNT_NORMAL, spoe);
            chk("result oe", (em == bnt_pkg::BNT_TREE) ? 4'hf : 4'h0, roe);
            if (em != bnt_pkg::BNT_HIZ)
                chk("comp", (em == bnt_pkg::BNT_TREE) ? 8'h88 : 8'ha5, {lcc, gcc});
            if (em != bnt_pkg::BNT_HIZ)
                chk("signaling", em == bnt_pkg::BNT_NORMAL, nsig);
        end
        tst.set_mode(4'h9);
        repeat (3) @(posedge clk_i);
        q[3:0] = exp_res();
        chk("tree one", q[0], res[0]);
        chk("tree two", q[1], res[1]);
        chk("tree three", q[2], res[2]);
        chk("tree four", q[3], res[3]);
        acc(0, `BNT_REG_STATUS, 0, 4'hf);
        chk("status res", exp_res(), q[5:2]);
        for (int k = 0; k < 4; k++)
            for (int i = 0; i < lens[k]; i++)
            begin
                pv = res[k];
                tst.clr(k, i);
                repeat (2) @(posedge clk_i);
                chk("tree walk", exp_res(), res);
                chk("tree flip", 1'b1, res[k] !== pv);
            end
        tst.set_mode(4'h0);
        repeat (3) @(posedge clk_i);
        chk("results off", 0, res);
        final_report();
    end
endmodule : tb_top

//--- core/bnt_mode_dec.sv
`timescale 1ns/1ps
module bnt_mode_dec
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // mode pins
    bnt_mode_if.dec mif
);

    bnt_pkg::bnt_mode_t mode_ff;
    bnt_pkg::bnt_mode_t nxt_mode;

    // ****************************************
    // mode decode
    // ****************************************
    always_comb
    begin
        nxt_mode = bnt_pkg::BNT_NORMAL;
        if (mif.test_pin && !mif.type_detect && !mif.link_halt_n)
        begin
            nxt_mode = mif.strap_zero ? bnt_pkg::BNT_TREE : bnt_pkg::BNT_HIZ;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_ff <= bnt_pkg::BNT_NORMAL;
        end
        else
        begin
            mode_ff <= nxt_mode;
        end
    end

    assign mif.mode = mode_ff;

endmodule : bnt_mode_dec

//--- core/bnt_mode_if.sv
`timescale 1ns/1ps
interface bnt_mode_if;
    logic test_pin;
    logic type_detect;
    logic link_halt_n;
    logic strap_zero;
    bnt_pkg::bnt_mode_t mode;

    modport dec
    (
        input test_pin,
        input type_detect,
        input link_halt_n,
        input strap_zero,
        output mode
    );
    modport user
    (
        output test_pin,
        output type_detect,
        output link_halt_n,
        output strap_zero,
        input mode
    );
endinterface : bnt_mode_if

//--- core/bnt_params.svh
// Contract
// - four pins decode normal, high-z or tree mode
// - high-z mode releases every signal pin
// - differential receive pairs merge into one input
// - tree one on strap five, last gate AND
// - tree one chains 32 side-B link inputs
// - tree two chains 57 side-A link inputs
// - tree three chains 80 graphics-port inputs
// - tree four chains 11 clock and reset inputs
// - mode pins and reference pins stay outside trees
// - tree mode forces mid-band input compensation
// - tree mode uses older graphics signaling
`ifndef BNT_PARAMS_SVH
`define BNT_PARAMS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define BNT_REG_STATUS 4'h0
`define BNT_REG_COMP 4'h4
`define BNT_REG_CTRL 4'h8

// ****************************************
// fields and reset values
// ****************************************
`define BNT_ST_MODE_LSB 0
`define BNT_ST_TREE_LSB 2
`define BNT_COMP_LINK_LSB 0
`define BNT_COMP_GFX_LSB 4
`define BNT_CTRL_DRIVE_BIT 0
`define BNT_CTRL_NEWSIG_BIT 1
`define BNT_COMP_RST 8'h88
`define BNT_CTRL_RST 2'h3
`define BNT_COMP_MIDBAND 4'h8

// ****************************************
// tree lengths
// ****************************************
`define BNT_T1_LEN 32
`define BNT_T2_LEN 57
`define BNT_T3_LEN 80
`define BNT_T4_LEN 11

`endif

//--- core/bnt_pkg.sv
package bnt_pkg;

    // gray along normal -> high-z -> tree
    typedef enum logic [1:0] {
        BNT_NORMAL = 2'h0,
        BNT_HIZ = 2'h1,
        BNT_TREE = 2'h3
    } bnt_mode_t;

endpackage : bnt_pkg

//--- core/bnt_top.sv
`timescale 1ns/1ps
`include "bnt_params.svh"
module bnt_top
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // mode select pins
    input wire logic test_pin_i,
    input wire logic port_type_detect_pin_i,
    input wire logic link_halt_request_pin_n_i,
    input wire logic strap_pin_zero_i,
    // side-B link: rx clock, 8 lines, ctl as pairs; tx legs in chain order
    input wire logic [9:0] rx_b_p_i,
    input wire logic [9:0] rx_b_n_i,
    input wire logic [17:0] tx_b_legs_i,
    input wire logic [2:0] link_comp_pins_i,
    input wire logic link_compensation_pin_three_i,
    // side-A link: rx pairs and tx legs in chain order
    input wire logic [18:0] rx_a_p_i,
    input wire logic [18:0] rx_a_n_i,
    input wire logic [37:0] tx_a_legs_i,
    // graphics port pins and straps in chain order
    input wire logic [79:0] gfx_pins_i,
    // clock, reset and strap pins in chain order
    input wire logic [10:0] sys_pins_i,
    // tree result straps: 0=tree one .. 3=tree four
    output logic tree_one_result_pin_o,
    output logic tree_two_result_pin_o,
    output logic tree_three_result_pin_o,
    output logic tree_four_result_pin_o,
    output logic [3:0] tree_result_oe_o,
    // pin drive control
    output logic sig_pin_oe_o,
    output logic [3:0] link_comp_code_o,
    output logic [3:0] gfx_comp_code_o,
    output logic gfx_new_signaling_o,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);

    // ****************************************
    // mode decoder
    // ****************************************
    bnt_mode_if mif();

    assign mif.test_pin = test_pin_i;
    assign mif.type_detect = port_type_detect_pin_i;
    assign mif.link_halt_n = link_halt_request_pin_n_i;
    assign mif.strap_zero = strap_pin_zero_i;

    bnt_mode_dec u_dec
    (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .mif(mif)
    );

    logic in_tree;
    logic in_hiz;

    assign in_tree = (mif.mode == bnt_pkg::BNT_TREE);
    assign in_hiz = (mif.mode == bnt_pkg::BNT_HIZ);

    // ****************************************
    // differential merge
    // ****************************************
    function automatic logic bnt_merge(input logic p, input logic n);
        return p & ~n;
    endfunction : bnt_merge

    logic [9:0] rx_b_se;
    logic [18:0] rx_a_se;

    always_comb
    begin
        for (int i = 0; i < 10; i++)
        begin
            rx_b_se[i] = bnt_merge(rx_b_p_i[i], rx_b_n_i[i]);
        end
        for (int i = 0; i < 19; i++)
        begin
            rx_a_se[i] = bnt_merge(rx_a_p_i[i], rx_a_n_i[i]);
        end
    end

    // ****************************************
    // tree chains
    // ****************************************
    logic [`BNT_T1_LEN-1:0] t1_in;
    logic [`BNT_T2_LEN-1:0] t2_in;
    logic [3:0] tree_res;

    // mode pins, strap zero, reference and calibration pins have no port here
    assign t1_in = {link_compensation_pin_three_i, link_comp_pins_i,
                    tx_b_legs_i, rx_b_se};
    assign t2_in = {tx_a_legs_i, rx_a_se};

    bnt_tree u_tree
    (
        .t1_i(t1_in),
        .t2_i(t2_in),
        .t3_i(gfx_pins_i),
        .t4_i(sys_pins_i),
        .res_o(tree_res)
    );

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] comp_ff;
    logic [7:0] nxt_comp;
    logic [1:0] ctrl_ff;
    logic [1:0] nxt_ctrl;
    logic wait_ff;
    logic nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    logic req;
    logic acc;

    assign req = avs_read_i | avs_write_i;
    assign acc = req & ~wait_ff;

    // ****************************************
    // bus slave
    // ****************************************
    always_comb
    begin
        nxt_wait = ~(req & wait_ff);
        nxt_comp = comp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rdata = rdata_ff;
        if (avs_read_i && wait_ff)
        begin
            unique case (avs_address_i)
                `BNT_REG_STATUS:
                begin
                    nxt_rdata = 32'h0;
                    nxt_rdata[`BNT_ST_MODE_LSB +: 2] = mif.mode;
                    nxt_rdata[`BNT_ST_TREE_LSB +: 4] = {tree_four_result_pin_o,
                        tree_three_result_pin_o, tree_two_result_pin_o,
                        tree_one_result_pin_o};
                end
                `BNT_REG_COMP:
                begin
                    nxt_rdata = {24'h0, comp_ff};
                end
                `BNT_REG_CTRL:
                begin
                    nxt_rdata = {30'h0, ctrl_ff};
                end
                default:
                begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
        if (acc && avs_write_i && avs_byteenable_i[0])
        begin
            if (avs_address_i == `BNT_REG_COMP)
            begin
                nxt_comp = avs_writedata_i[7:0];
            end
            if (avs_address_i == `BNT_REG_CTRL)
            begin
                nxt_ctrl = avs_writedata_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wait_ff <= 1'b1;
            comp_ff <= `BNT_COMP_RST;
            ctrl_ff <= `BNT_CTRL_RST;
            rdata_ff <= 32'h0;
        end
        else
        begin
            wait_ff <= nxt_wait;
            comp_ff <= nxt_comp;
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest_o = wait_ff;
    assign avs_readdata_o = rdata_ff;

    // ****************************************
    // pin outputs
    // ****************************************
    logic [3:0] res_ff;
    logic [3:0] nxt_res;
    logic [3:0] res_oe_ff;
    logic [3:0] nxt_res_oe;
    logic sig_oe_ff;
    logic nxt_sig_oe;
    logic [3:0] lcomp_ff;
    logic [3:0] nxt_lcomp;
    logic [3:0] gcomp_ff;
    logic [3:0] nxt_gcomp;
    logic newsig_ff;
    logic nxt_newsig;

    always_comb
    begin
        nxt_res = in_tree ? tree_res : 4'h0;
        nxt_res_oe = in_tree ? 4'hf : 4'h0;
        nxt_sig_oe = ctrl_ff[`BNT_CTRL_DRIVE_BIT] & ~in_hiz & ~in_tree;
        nxt_lcomp = comp_ff[`BNT_COMP_LINK_LSB +: 4];
        nxt_gcomp = comp_ff[`BNT_COMP_GFX_LSB +: 4];
        nxt_newsig = ctrl_ff[`BNT_CTRL_NEWSIG_BIT];
        if (in_tree)
        begin
            nxt_lcomp = `BNT_COMP_MIDBAND;
            nxt_gcomp = `BNT_COMP_MIDBAND;
            nxt_newsig = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            res_ff <= 4'h0;
            res_oe_ff <= 4'h0;
            sig_oe_ff <= 1'b0;
            lcomp_ff <= `BNT_COMP_MIDBAND;
            gcomp_ff <= `BNT_COMP_MIDBAND;
            newsig_ff <= 1'b0;
        end
        else
        begin
            res_ff <= nxt_res;
            res_oe_ff <= nxt_res_oe;
            sig_oe_ff <= nxt_sig_oe;
            lcomp_ff <= nxt_lcomp;
            gcomp_ff <= nxt_gcomp;
            newsig_ff <= nxt_newsig;
        end
    end

    assign tree_one_result_pin_o = res_ff[0];
    assign tree_two_result_pin_o = res_ff[1];
    assign tree_three_result_pin_o = res_ff[2];
    assign tree_four_result_pin_o = res_ff[3];
    assign tree_result_oe_o = res_oe_ff;
    assign sig_pin_oe_o = sig_oe_ff;
    assign link_comp_code_o = lcomp_ff;
    assign gfx_comp_code_o = gcomp_ff;
    assign gfx_new_signaling_o = newsig_ff;

endmodule : bnt_top

//--- core/bnt_tree.sv
`timescale 1ns/1ps
`include "bnt_params.svh"
module bnt_tree
(
    // merged chain inputs, bit 0 is chain position one
    input wire logic [`BNT_T1_LEN-1:0] t1_i,
    input wire logic [`BNT_T2_LEN-1:0] t2_i,
    input wire logic [`BNT_T3_LEN-1:0] t3_i,
    input wire logic [`BNT_T4_LEN-1:0] t4_i,
    // tree results
    output logic [3:0] res_o
);

    // ****************************************
    // chain of gates, first gate tied high
    // ****************************************
    function automatic logic bnt_chain(input logic [79:0] v, input int unsigned n,
                                       input logic last_and);
        logic s;
        s = 1'b1;
        for (int unsigned i = 0; i < 80; i++)
        begin
            if (i < n)
            begin
                if (last_and && (i == n - 1))
                begin
                    s = s & v[i];
                end
                else
                begin
                    s = ~(s & v[i]);
                end
            end
        end
        return s;
    endfunction : bnt_chain

    always_comb
    begin
        res_o[0] = bnt_chain({48'h0, t1_i}, `BNT_T1_LEN, 1'b1);
        res_o[1] = bnt_chain({23'h0, t2_i}, `BNT_T2_LEN, 1'b0);
        res_o[2] = bnt_chain(t3_i, `BNT_T3_LEN, 1'b0);
        res_o[3] = bnt_chain({69'h0, t4_i}, `BNT_T4_LEN, 1'b0);
    end

endmodule : bnt_tree
